// [timer_irq_map.svh]
/*
  Register offsets, bit positions and codes of the countdown timer.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

// Register offsets
`define TMR_ADDR_CTRL2 8'h01
`define TMR_ADDR_TCTRL 8'h0E
`define TMR_ADDR_PRESET 8'h0F

// Control 2 bit positions
`define TMR_BIT_TIE 0
`define TMR_BIT_TF 2
`define TMR_BIT_MODE 4

// Timer control bit positions
`define TMR_BIT_SEL_HI 1
`define TMR_BIT_SEL_LO 0
`define TMR_BIT_PIN 6
`define TMR_BIT_TE 7

// Source select codes
`define TMR_SEL_4096 2'h0
`define TMR_SEL_64 2'h1
`define TMR_SEL_SEC 2'h2
`define TMR_SEL_MIN 2'h3

// Count values, reset values and the pin drive level
`define TMR_CNT_ONE 8'h01
`define TMR_CNT_ZERO 8'h00
`define TMR_RST_BYTE 8'h00
`define TMR_MODE_LEVEL 1'h0
`define TMR_PIN_LOW 1'h0

`endif

// [timer_irq_pkg.sv]
/*
  Types of the countdown timer.
  Assumes nothing of its surroundings.
*/
package timer_irq_pkg;

  // Repeated-mode pulse on the interrupt pin
  typedef enum logic {
    PULSE_IDLE,
    PULSE_ACTIVE
  } pulse_state_t;

  typedef logic [1:0] src_sel_t;

endpackage

// [fixed_cycle_timer_irq.sv]
/*
  Fixed-cycle countdown timer with event flag and open-drain interrupt pin.
  Assumes single-cycle source ticks on clk, a register port from the serial
  host interface on clk, and an outside pull-up on the interrupt wire.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_map.svh"

module fixed_cycle_timer_irq #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick_4096hz,
  input wire logic tick_64hz,
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [CNT_W-1:0] reg_wdata,
  output logic [CNT_W-1:0] reg_rdata,
  input wire logic timer_irq_out_n_i,
  output logic timer_irq_out_n_o,
  output logic timer_irq_out_n_oe_n
);

  //////////////////////////////////////////////////////////////////////
  // Declarations

  logic wr_ctrl2, wr_tctrl, wr_preset;
  logic start, stop, running, src_tick, rtn_tick, evt;
  logic tie_q, tie_d, tf_q, tf_d, mode_q, mode_d;
  logic te_q, te_d, valid_q, valid_d;
  timer_irq_pkg::src_sel_t sel_q, sel_d;
  logic [CNT_W-1:0] preset_q, preset_d, cnt_q, cnt_d;
  timer_irq_pkg::pulse_state_t pst_q, pst_d;
  logic drive_q, drive_d;
  logic pin_meta_q, pin_sync_q;
  logic [CNT_W-1:0] rdata_q, rdata_d, rd_mux;

  //////////////////////////////////////////////////////////////////////
  // Address decode and run qualifiers

  assign wr_ctrl2 = reg_wr && (reg_addr == `TMR_ADDR_CTRL2);
  assign wr_tctrl = reg_wr && (reg_addr == `TMR_ADDR_TCTRL);
  assign wr_preset = reg_wr && (reg_addr == `TMR_ADDR_PRESET);
  assign start = wr_tctrl && reg_wdata[`TMR_BIT_TE] && !te_q;
  assign stop = wr_tctrl && !reg_wdata[`TMR_BIT_TE] && te_q;
  // A start without a fresh preset never counts
  assign running = te_q && valid_q;
  assign evt = running && src_tick && (cnt_q == `TMR_CNT_ONE);

  // Source tick select; free-running ticks leave the first period short
  always_comb begin
    case (sel_q)
      `TMR_SEL_4096: src_tick = tick_4096hz;
      `TMR_SEL_64: src_tick = tick_64hz;
      `TMR_SEL_SEC: src_tick = sec_tick;
      default: src_tick = min_tick;
    endcase
  end

  // Pulse release: one source tick, or one 64 Hz tick for slow sources
  assign rtn_tick = sel_q[`TMR_BIT_SEL_HI] ? tick_64hz : src_tick;

  //////////////////////////////////////////////////////////////////////
  // Control and flag bits

  always_comb begin
    tie_d = wr_ctrl2 ? reg_wdata[`TMR_BIT_TIE] : tie_q;
    mode_d = wr_ctrl2 ? reg_wdata[`TMR_BIT_MODE] : mode_q;
    te_d = wr_tctrl ? reg_wdata[`TMR_BIT_TE] : te_q;
    sel_d = wr_tctrl ? reg_wdata[`TMR_BIT_SEL_HI:`TMR_BIT_SEL_LO] : sel_q;
    // Set beats a clear arriving in the same cycle
    if (evt) begin
      tf_d = 1'h1;
    end else if (wr_ctrl2 && !reg_wdata[`TMR_BIT_TF]) begin
      tf_d = 1'h0;
    end else begin
      tf_d = tf_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tie_q <= 1'h0;
      tf_q <= 1'h0;
      mode_q <= `TMR_MODE_LEVEL;
      te_q <= 1'h0;
      sel_q <= `TMR_SEL_4096;
    end else begin
      tie_q <= tie_d;
      tf_q <= tf_d;
      mode_q <= mode_d;
      te_q <= te_d;
      sel_q <= sel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Preset and down counter

  always_comb begin
    preset_d = preset_q;
    valid_d = valid_q;
    cnt_d = cnt_q;
    if (stop) begin
      valid_d = 1'h0;
      cnt_d = `TMR_CNT_ZERO;
    end else if (wr_preset && !te_q) begin
      // Preset taken only while stopped; zero is not a usable count
      preset_d = reg_wdata;
      valid_d = (reg_wdata != `TMR_CNT_ZERO);
      cnt_d = reg_wdata;
    end else if (start) begin
      cnt_d = preset_q;
    end else if (evt) begin
      cnt_d = preset_q;
    end else if (running && src_tick) begin
      cnt_d = cnt_q - `TMR_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preset_q <= `TMR_RST_BYTE;
      valid_q <= 1'h0;
      cnt_q <= `TMR_RST_BYTE;
    end else begin
      preset_q <= preset_d;
      valid_q <= valid_d;
      cnt_q <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Repeated-mode pulse and pin drive

  always_comb begin
    case (pst_q)
      timer_irq_pkg::PULSE_IDLE: begin
        pst_d = (evt && mode_q) ? timer_irq_pkg::PULSE_ACTIVE : pst_q;
      end
      timer_irq_pkg::PULSE_ACTIVE: begin
        // Flag clear does not shorten a running pulse
        if (evt) begin
          pst_d = timer_irq_pkg::PULSE_ACTIVE;
        end else if (rtn_tick) begin
          pst_d = timer_irq_pkg::PULSE_IDLE;
        end else begin
          pst_d = pst_q;
        end
      end
      default: pst_d = timer_irq_pkg::PULSE_IDLE;
    endcase
    // Level mode follows flag and enable; run enable plays no part
    if (mode_q) begin
      drive_d = (pst_q == timer_irq_pkg::PULSE_ACTIVE) && tie_q;
    end else begin
      drive_d = tf_q && tie_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pst_q <= timer_irq_pkg::PULSE_IDLE;
      drive_q <= 1'h0;
    end else begin
      pst_q <= pst_d;
      drive_q <= drive_d;
    end
  end

  // Open-drain: only ever pulls low, enable low while pulling
  assign timer_irq_out_n_o = `TMR_PIN_LOW;
  assign timer_irq_out_n_oe_n = !drive_q;

  //////////////////////////////////////////////////////////////////////
  // Pin level sense and read data

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_q <= 1'h1;
      pin_sync_q <= 1'h1;
    end else begin
      pin_meta_q <= timer_irq_out_n_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Counter read is live; software reads twice to be sure
  always_comb begin
    rd_mux = `TMR_RST_BYTE;
    case (reg_addr)
      `TMR_ADDR_CTRL2: begin
        rd_mux[`TMR_BIT_TIE] = tie_q;
        rd_mux[`TMR_BIT_TF] = tf_q;
        rd_mux[`TMR_BIT_MODE] = mode_q;
      end
      `TMR_ADDR_TCTRL: begin
        rd_mux[`TMR_BIT_SEL_HI:`TMR_BIT_SEL_LO] = sel_q;
        rd_mux[`TMR_BIT_PIN] = pin_sync_q;
        rd_mux[`TMR_BIT_TE] = te_q;
      end
      `TMR_ADDR_PRESET: rd_mux = cnt_q;
      default: rd_mux = `TMR_RST_BYTE;
    endcase
    rdata_d = reg_rd ? rd_mux : rdata_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `TMR_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic clr_wr;
  assign clr_wr = wr_ctrl2 && !reg_wdata[`TMR_BIT_TF];

  sequence s_enable_rise;
    !mode_q && tf_q && !tie_q ##1 !mode_q && tf_q && tie_q;
  endsequence

  sequence s_level_clear;
    !mode_q && tf_q && clr_wr && !reg_wdata[`TMR_BIT_MODE] && !evt;
  endsequence

  a_flag_holds: assert property (tf_q && !clr_wr |=> tf_q)
    else $error("event flag dropped without a clear");

  a_flag_clear: assert property (tf_q && clr_wr && !evt |=> !tf_q)
    else $error("zero write did not clear event flag");

  a_flag_one_write: assert property (
    !tf_q && wr_ctrl2 && reg_wdata[`TMR_BIT_TF] && !evt |=> !tf_q)
    else $error("one write changed event flag");

  a_level_release: assert property (s_level_clear |=> ##1 timer_irq_out_n_oe_n)
    else $error("pin not released after flag clear");

  a_event_sets: assert property (evt |=> tf_q)
    else $error("event did not set flag");

  a_irq_on_event: assert property (
    evt && tie_q && !wr_ctrl2 |=> ##1 !timer_irq_out_n_oe_n)
    else $error("enabled event did not pull pin low");

  a_irq_disabled: assert property (
    !tie_q && !wr_ctrl2 |-> ##2 timer_irq_out_n_oe_n)
    else $error("pin pulled low with enable clear");

  a_enable_raise: assert property (s_enable_rise |=> !timer_irq_out_n_oe_n)
    else $error("enable rise did not pull pin low");

  a_enable_follow: assert property (
    !mode_q && tf_q && tie_q |=> !timer_irq_out_n_oe_n)
    else $error("pin not driven with flag and enable set");

  a_count_step: assert property (
    running && src_tick && cnt_q > `TMR_CNT_ONE && !wr_tctrl
    |=> cnt_q == $past(cnt_q) - `TMR_CNT_ONE)
    else $error("counter did not step on selected tick");

  a_count_idle: assert property (
    running && !src_tick && !wr_tctrl |=> $stable(cnt_q))
    else $error("counter moved without a tick");

  a_reload: assert property (evt && !wr_tctrl |=> cnt_q == preset_q && te_q)
    else $error("preset not reloaded after event");

  a_start_load: assert property (start |=> te_q && cnt_q == preset_q)
    else $error("start did not load preset");

  a_stop_keeps: assert property (stop && tf_q |=> tf_q && !valid_q)
    else $error("stop cleared flag or kept preset");

  a_stop_invalid: assert property (
    stop |=> !running && cnt_q == `TMR_CNT_ZERO)
    else $error("count still valid after stop");

  a_flag_low_release: assert property (
    !mode_q && !tf_q && !evt && !wr_ctrl2 |-> ##2 timer_irq_out_n_oe_n)
    else $error("pin driven with flag clear");

  a_pulse_drive: assert property (
    mode_q && tie_q && pst_q == timer_irq_pkg::PULSE_ACTIVE && !wr_ctrl2
    |=> !timer_irq_out_n_oe_n)
    else $error("repeated pulse not driven");

  a_pin_value: assert property (timer_irq_out_n_o == `TMR_PIN_LOW)
    else $error("open-drain pin driven high");

endmodule
`default_nettype wire

// [irq_host_model.sv]
/*
  Wire model of the interrupt line as the watching processor sees it.
  Assumes an outside pull-up and a device that only ever pulls low.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_host_model (
  input wire logic drive_o,
  input wire logic drive_oe_n,
  output logic wire_level
);
  // Pull-up wins whenever the open-drain driver lets go
  assign wire_level = drive_oe_n ? 1'h1 : drive_o;
endmodule

`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for the countdown timer: every register read leaves
  a note in a queue, and a monitor compares each answer with the oldest note.
  Assumes the wire model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk;
  logic arst_n;
  logic reg_wr;
  logic reg_rd;
  logic pend = 1'h0;
  logic [3:0] ticks;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] e;
  logic [7:0] s;
  logic [7:0] exp_q[$];
  logic pin_o;
  logic pin_oe_n;
  logic pin_level;
  int mismatches;
  int comparisons;
  int n;

  fixed_cycle_timer_irq fixed_cycle_timer_irq_i (.clk(clk), .arst_n(arst_n), .tick_4096hz(ticks[0]),
    .tick_64hz(ticks[1]), .sec_tick(ticks[2]), .min_tick(ticks[3]), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_irq_out_n_i(pin_level),
    .timer_irq_out_n_o(pin_o), .timer_irq_out_n_oe_n(pin_oe_n));
  irq_host_model irq_host_model_i (.drive_o(pin_o), .drive_oe_n(pin_oe_n), .wire_level(pin_level));

  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Read answer lands one edge after the strobe; an empty queue gives X and fails
  always @(posedge clk) begin
    if (pend === 1'h1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
      comparisons++;
      if (reg_rdata !== e) begin
        $display("wrong value at %0t: got %0h expected %0h", $time, reg_rdata, e);
        mismatches++;
      end
    end
    pend <= reg_rd;
  end

  // Write, then idle long enough for the registered pin and its two sync flops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(x);
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask

  // Unselected sources pulse first, so a wrong select shows as a wrong count
  task automatic tk(input int k);
    @(posedge clk);
    ticks <= ~(4'h1 << k);
    @(posedge clk);
    ticks <= 4'h1 << k;
    @(posedge clk);
    ticks <= 4'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (exp_q.size() != 0) mismatches++;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    ticks = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(79));
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    rd(8'h01, 8'h00);
    rd(8'h0E, 8'h40);
    rd(8'h0F, 8'h00);
    $display("test reset values done");
    // Every source select, random preset, full flag and pin sequence
    for (int k = 0; k < 4; k++) begin
      s = 8'(k);
      n = 2 + ($urandom % 4);
      wr(8'h0E, s);
      wr(8'h0F, 8'(n));
      wr(8'h01, 8'h01);
      tk(k);
      rd(8'h0F, 8'(n));
      wr(8'h0E, 8'h80 | s);
      for (int j = 1; j < n; j++) begin
        tk(k);
        rd(8'h0F, 8'(n - j));
        rd(8'h01, 8'h01);
      end
      tk(k);
      rd(8'h0F, 8'(n));
      rd(8'h01, 8'h05);
      rd(8'h0E, 8'h80 | s);
      wr(8'h01, 8'h05);
      rd(8'h01, 8'h05);
      wr(8'h01, 8'h04);
      rd(8'h0E, 8'hC0 | s);
      wr(8'h01, 8'h05);
      rd(8'h0E, 8'h80 | s);
      wr(8'h0E, s);
      rd(8'h01, 8'h05);
      rd(8'h0E, s);
      rd(8'h0F, 8'h00);
      wr(8'h01, 8'h01);
      rd(8'h0E, 8'h40 | s);
      $display("test select %0d done", k);
    end
    // Masked output, refused preset write, repeat after clear, mode bit
    wr(8'h0E, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h0F, 8'h01);
    wr(8'h0E, 8'h80);
    wr(8'h0F, 8'h09);
    rd(8'h0F, 8'h01);
    tk(0);
    rd(8'h01, 8'h04);
    rd(8'h0E, 8'hC0);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    tk(0);
    rd(8'h01, 8'h04);
    wr(8'h01, 8'h11);
    rd(8'h01, 8'h11);
    // Repeated mode: event pulses the pin, flag clear keeps the pulse, next tick ends it
    tk(0);
    rd(8'h01, 8'h15);
    rd(8'h0F, 8'h01);
    rd(8'h0E, 8'h80);
    wr(8'h01, 8'h11);
    rd(8'h0E, 8'h80);
    wr(8'h0E, 8'h00);
    tk(0);
    rd(8'h0E, 8'h40);
    $display("test masked and repeat done");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule

`default_nettype wire
